// File: hw/cap_bank.sv
// Charge algorithm parameter bank with its charge phase sequencer
module cap_bank
	import cap_pkg::*;
#(
	parameter int TICK_CYCLES = CAP_TICK_CYCLES
)(
	// Clock and reset
	input  wire logic        mclk,
	input  wire logic        rst_n,
	// Chemistry strap pins
	input  wire logic [2:0]  chem_pin,
	// Register port
	input  wire logic        reg_wr,
	input  wire logic        reg_rd,
	input  wire logic [7:0]  reg_addr,
	input  wire logic [15:0] reg_wdata,
	output logic      [15:0] reg_rdata_q,
	// Charger side
	input  wire logic        charge_en,
	input  wire logic        equalize_req,
	input  wire logic [5:0]  charge_voltage_code,
	input  wire logic [4:0]  charge_current_code,
	input  wire cap_meas_t   meas,
	output cap_target_t      target_q,
	output logic             charge_pause_q,
	output logic             terminated_q,
	output logic             time_fault_q,
	output logic [15:0]      recharge_level_q
);

	// Strap synchroniser and settle counter
	logic [2:0]  pin_s1_q, pin_s2_q, pin_s3_q;
	logic [2:0]  strap_q;             // Accepted strap code
	logic [1:0]  settle_q;            // Agreeing samples before defaults load
	logic        ready_q;             // Defaults loaded
	cap_chem_t   chem;
	logic        programmable;
	logic        lithium;

	// Bank contents
	logic [15:0] taper_current_threshold_q;
	logic [15:0] cv_time_limit_q;
	logic [15:0] total_charge_time_limit_q;
	logic [15:0] temp_breakpoint_q [6];
	logic [9:0]  region_voltage_codes_hi_q;
	logic [14:0] region_voltage_codes_lo_q;
	logic [9:0]  region_current_codes_hi_q;
	logic [14:0] region_current_codes_lo_q;
	logic [2:0]  cfg_q;
	logic [5:0]  absorb_adder_q;
	logic [15:0] absorb_time_limit_q;
	logic [5:0]  equalize_adder_q;
	logic [15:0] equalize_duration_q;

	// Timers and sequencer
	logic [26:0] tick_cnt_q;
	logic        tick_q;
	logic [15:0] total_sec_q, cv_elapsed_seconds_q, absorb_sec_q, eq_sec_q;
	cap_state_t  state_q, state_d;
	logic        wr_ok;
	logic [5:0]  below_bp;
	logic [2:0]  region;
	logic        region_off;
	logic        taper_hit;
	logic        prof_on;
	logic [6:0]  base;                // Charge code widened to level width
	logic [6:0]  sum_abs;             // Absorb adder plus charge code
	logic [6:0]  sum_eq;              // Equalize adder plus charge code

	// Three-stage strap sampling, first stage feeds only the second
	always_ff @(posedge mclk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			pin_s1_q <= 3'h0;
			pin_s2_q <= 3'h0;
			pin_s3_q <= 3'h0;
		end
		else
		begin
			pin_s1_q <= chem_pin;
			pin_s2_q <= pin_s1_q;
			pin_s3_q <= pin_s2_q;
		end
	end

	// Strap taken once two later stages agree; counted to let it settle
	always_ff @(posedge mclk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			strap_q  <= 3'h0;
			settle_q <= 2'h0;
			ready_q  <= 1'b0;
		end
		else if (pin_s2_q == pin_s3_q)
		begin
			strap_q <= pin_s3_q;
			if (settle_q != CAP_STRAP_SETTLE)
				settle_q <= settle_q + 2'h1;
			else
				ready_q <= 1'b1;
		end
	end

	// Decode chemistry and programmability
	always_comb
	begin
		programmable = (strap_q == CAP_PIN_LI_PROG) || (strap_q == CAP_PIN_LFP_PROG) ||
			(strap_q == CAP_PIN_LEAD_PROG);
		if ((strap_q == CAP_PIN_LI_PROG) || (strap_q == CAP_PIN_LI_FIX))
			chem = CHEM_LI_ION;
		else if ((strap_q == CAP_PIN_LFP_PROG) || (strap_q == CAP_PIN_LFP_FIX))
			chem = CHEM_LFP;
		else
			chem = CHEM_LEAD;
		lithium = (chem != CHEM_LEAD);
	end

	// Writes land only once defaults are in and the strap is programmable
	assign wr_ok = reg_wr && ready_q && programmable;

	// Scalar bank registers; chemistry defaults load when the strap settles
	always_ff @(posedge mclk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			taper_current_threshold_q <= CAP_RST_TAPER_THR;
			cv_time_limit_q           <= CAP_RST_CV_LI_ION;
			total_charge_time_limit_q <= CAP_RST_TOTAL_LIMIT;
			cfg_q                     <= 3'h3;
			absorb_adder_q            <= CAP_RST_ADDER;
			absorb_time_limit_q       <= CAP_RST_ABSORB_LIM;
			equalize_adder_q          <= CAP_RST_ADDER;
			equalize_duration_q       <= CAP_RST_EQ_TIME;
			recharge_level_q          <= CAP_RST_RECHARGE;
		end
		else if (!ready_q)
		begin
			// Chemistry-dependent defaults follow the settling strap
			cv_time_limit_q <= (chem == CHEM_LFP) ? CAP_RST_CV_LFP : CAP_RST_CV_LI_ION;
			cfg_q           <= {1'b0, !lithium, lithium};
		end
		else if (wr_ok)
		begin
			case (reg_addr)
				CAP_ADDR_TAPER_THR:   taper_current_threshold_q <= reg_wdata;
				CAP_ADDR_CV_LIMIT:    cv_time_limit_q           <= reg_wdata;
				CAP_ADDR_TOTAL_LIMIT: total_charge_time_limit_q <= reg_wdata;
				CAP_ADDR_CFG:         cfg_q                     <= reg_wdata[2:0];
				CAP_ADDR_ABSORB_ADD:  absorb_adder_q            <= reg_wdata[5:0];
				CAP_ADDR_ABSORB_LIM:  absorb_time_limit_q       <= reg_wdata;
				CAP_ADDR_EQ_ADD:      equalize_adder_q          <= reg_wdata[5:0];
				CAP_ADDR_EQ_TIME:     equalize_duration_q       <= reg_wdata;
				CAP_ADDR_RECHARGE:    recharge_level_q          <= reg_wdata;
				default:              ;
			endcase
		end
	end

	// Packed region codes, one field of five bits per region
	always_ff @(posedge mclk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			region_voltage_codes_hi_q <= CAP_RST_CODE_HI;
			region_voltage_codes_lo_q <= CAP_RST_CODE_LO;
			region_current_codes_hi_q <= CAP_RST_CODE_HI;
			region_current_codes_lo_q <= CAP_RST_CODE_LO;
		end
		else if (wr_ok)
		begin
			case (reg_addr)
				CAP_ADDR_VCODE_HI: region_voltage_codes_hi_q <= reg_wdata[9:0];
				CAP_ADDR_VCODE_LO: region_voltage_codes_lo_q <= reg_wdata[14:0];
				CAP_ADDR_ICODE_HI: region_current_codes_hi_q <= reg_wdata[9:0];
				CAP_ADDR_ICODE_LO: region_current_codes_lo_q <= reg_wdata[14:0];
				default:           ;
			endcase
		end
	end

	// Breakpoints and their comparisons, one per entry
	for (genvar i = 0; i < 6; i++)
	begin : g_bp
		localparam logic [7:0] ADDR = CAP_ADDR_BP_FIRST + 8'(i);
		// Default ladder falls from cold to warm
		always_ff @(posedge mclk or negedge rst_n)
		begin
			if (!rst_n)
				temp_breakpoint_q[i] <= CAP_RST_BP_TOP - 16'(i) * CAP_RST_BP_STEP;
			else if (wr_ok && (reg_addr == ADDR))
				temp_breakpoint_q[i] <= reg_wdata;
		end
		// Ratio falls as it warms, so at or below means past this point
		assign below_bp[i] = (meas.ntc_ratio <= temp_breakpoint_q[i]);
	end

	// Region 1 is coldest; each breakpoint passed adds one
	always_comb
	begin
		region = 3'h1;
		for (int k = 0; k < 6; k++)
			region = region + {2'h0, below_bp[k]};
		region_off = (region == 3'h1) || (region == 3'h7);
	end

	// Pick a five-bit field from the packed pair for a region
	function automatic logic [4:0] pick_code(input logic [2:0] rg, input logic [9:0] hi,
		input logic [14:0] lo);
		case (rg)
			3'h2:    pick_code = lo[4:0];
			3'h3:    pick_code = lo[9:5];
			3'h4:    pick_code = lo[14:10];
			3'h5:    pick_code = hi[4:0];
			3'h6:    pick_code = hi[9:5];
			default: pick_code = 5'h00;
		endcase
	endfunction : pick_code

	// One-second tick from the system clock
	always_ff @(posedge mclk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			tick_cnt_q <= 27'h0;
			tick_q     <= 1'b0;
		end
		else if (tick_cnt_q == 27'(TICK_CYCLES - 1))
		begin
			tick_cnt_q <= 27'h0;
			tick_q     <= 1'b1;
		end
		else
		begin
			tick_cnt_q <= tick_cnt_q + 27'h1;
			tick_q     <= 1'b0;
		end
	end

	// Taper qualifier; a zero threshold switches detection off
	assign taper_hit = (taper_current_threshold_q != 16'h0) && meas.at_target_voltage &&
		($signed(meas.battery_current_reading) < $signed(taper_current_threshold_q));
	assign prof_on = lithium && cfg_q[CAP_CFG_PROF_EN];

	// Phase sequencer
	always_comb
	begin
		state_d = state_q;
		case (state_q)
			ST_IDLE:
				if (charge_en && ready_q)
				begin
					// Lead-acid always absorbs; iron-phosphate unless the low five adder bits are zero
					if ((chem == CHEM_LEAD) || ((chem == CHEM_LFP) && (absorb_adder_q[4:0] != 5'h0)))
						state_d = ST_ABSORB;
					else
						state_d = ST_CCCV;
				end
			ST_CCCV:
				if (lithium && (total_sec_q > total_charge_time_limit_q))
					state_d = ST_TIME_FAULT;
				else if (prof_on && region_off)
					state_d = ST_PAUSE;
				else if (lithium && cfg_q[CAP_CFG_TAPER_EN] && taper_hit)
					state_d = ST_TAPER_TERM;
				else if (lithium && (cv_elapsed_seconds_q >= cv_time_limit_q))
					state_d = ST_TIMER_TERM;
				else if ((chem == CHEM_LEAD) && equalize_req)
					state_d = ST_EQUALIZE;
			ST_ABSORB:
				if (taper_hit || (absorb_sec_q >= absorb_time_limit_q))
					state_d = ST_CCCV;
			ST_EQUALIZE:
				if (eq_sec_q >= equalize_duration_q)
					state_d = ST_CCCV;
			ST_PAUSE:
				if (!(prof_on && region_off))
					state_d = ST_CCCV;
			ST_TIMER_TERM, ST_TAPER_TERM, ST_TIME_FAULT:
				state_d = state_q;
			default:
				state_d = ST_IDLE;
		endcase
		// Charger withdrawal restarts the cycle
		if (!charge_en)
			state_d = ST_IDLE;
	end

	// Sequencer state register
	always_ff @(posedge mclk or negedge rst_n)
	begin
		if (!rst_n)
			state_q <= ST_IDLE;
		else
			state_q <= state_d;
	end

	// Second counters; each phase counter clears when its phase is left, the total one in idle
	always_ff @(posedge mclk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			total_sec_q          <= 16'h0;
			cv_elapsed_seconds_q <= 16'h0;
			absorb_sec_q         <= 16'h0;
			eq_sec_q             <= 16'h0;
		end
		else
		begin
			if (state_q == ST_IDLE)
				total_sec_q <= 16'h0;
			else if (tick_q && lithium && (total_sec_q != 16'hFFFF))
				total_sec_q <= total_sec_q + 16'h1;
			if ((state_q != ST_CCCV) || !meas.at_target_voltage)
				cv_elapsed_seconds_q <= 16'h0;
			else if (tick_q && lithium)
				cv_elapsed_seconds_q <= cv_elapsed_seconds_q + 16'h1;
			if (state_q != ST_ABSORB)
				absorb_sec_q <= 16'h0;
			else if (tick_q)
				absorb_sec_q <= absorb_sec_q + 16'h1;
			if (state_q != ST_EQUALIZE)
				eq_sec_q <= 16'h0;
			else if (tick_q)
				eq_sec_q <= eq_sec_q + 16'h1;
		end
	end

	// Level sums ahead of their clamps; seven bits so no carry is lost
	always_comb
	begin
		base   = {1'b0, charge_voltage_code};
		sum_eq = {1'b0, equalize_adder_q} + base;
		if (chem == CHEM_LFP)
			sum_abs = {2'h0, absorb_adder_q[4:0]} + base;
		else
			sum_abs = {1'b0, absorb_adder_q} + base;
	end

	// Voltage and current targets for the loops
	always_ff @(posedge mclk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			target_q       <= '0;
			charge_pause_q <= 1'b0;
			terminated_q   <= 1'b0;
			time_fault_q   <= 1'b0;
		end
		else
		begin
			if (prof_on)
			begin
				// Region codes replace the charge codes
				target_q.voltage_code <= {2'h0, pick_code(region, region_voltage_codes_hi_q,
					region_voltage_codes_lo_q)};
				target_q.current_code <= pick_code(region, region_current_codes_hi_q,
					region_current_codes_lo_q);
			end
			else if ((state_q == ST_ABSORB) && (chem == CHEM_LFP))
			begin
				target_q.voltage_code <= (sum_abs > CAP_LFP_CODE_MAX) ? CAP_LFP_CODE_MAX : sum_abs;
				target_q.current_code <= charge_current_code;
			end
			else if ((state_q == ST_ABSORB) && (chem == CHEM_LEAD))
			begin
				target_q.voltage_code <= (sum_abs > CAP_LEAD_CODE_MAX) ? CAP_LEAD_CODE_MAX : sum_abs;
				target_q.current_code <= charge_current_code;
			end
			else if ((state_q == ST_EQUALIZE) && (chem == CHEM_LEAD))
			begin
				target_q.voltage_code <= (sum_eq > CAP_LEAD_CODE_MAX) ? CAP_LEAD_CODE_MAX : sum_eq;
				target_q.current_code <= charge_current_code;
			end
			else
			begin
				target_q.voltage_code <= base;
				target_q.current_code <= charge_current_code;
			end
			// Compensation only matters for lead-acid
			target_q.temp_comp_en <= (chem == CHEM_LEAD) && cfg_q[CAP_CFG_TCOMP_EN];
			charge_pause_q <= (state_q == ST_PAUSE) || (state_q == ST_IDLE);
			terminated_q   <= (state_q == ST_TIMER_TERM) || (state_q == ST_TAPER_TERM);
			time_fault_q   <= (state_q == ST_TIME_FAULT);
		end
	end

	// Read port: answer one cycle after the strobe, unmapped reads zero
	always_ff @(posedge mclk or negedge rst_n)
	begin
		if (!rst_n)
			reg_rdata_q <= 16'h0;
		else if (reg_rd)
		begin
			case (reg_addr)
				CAP_ADDR_TAPER_THR:   reg_rdata_q <= taper_current_threshold_q;
				CAP_ADDR_CV_LIMIT:    reg_rdata_q <= cv_time_limit_q;
				CAP_ADDR_TOTAL_LIMIT: reg_rdata_q <= total_charge_time_limit_q;
				CAP_ADDR_VCODE_HI:    reg_rdata_q <= {6'h0, region_voltage_codes_hi_q};
				CAP_ADDR_VCODE_LO:    reg_rdata_q <= {1'b0, region_voltage_codes_lo_q};
				CAP_ADDR_ICODE_HI:    reg_rdata_q <= {6'h0, region_current_codes_hi_q};
				CAP_ADDR_ICODE_LO:    reg_rdata_q <= {1'b0, region_current_codes_lo_q};
				CAP_ADDR_CFG:         reg_rdata_q <= {13'h0, cfg_q};
				CAP_ADDR_ABSORB_ADD:  reg_rdata_q <= {10'h0, absorb_adder_q};
				CAP_ADDR_ABSORB_LIM:  reg_rdata_q <= absorb_time_limit_q;
				CAP_ADDR_EQ_ADD:      reg_rdata_q <= {10'h0, equalize_adder_q};
				CAP_ADDR_EQ_TIME:     reg_rdata_q <= equalize_duration_q;
				CAP_ADDR_RECHARGE:    reg_rdata_q <= recharge_level_q;
				CAP_ADDR_TOTAL_SEC:   reg_rdata_q <= total_sec_q;
				CAP_ADDR_CV_SEC:      reg_rdata_q <= cv_elapsed_seconds_q;
				CAP_ADDR_ABSORB_SEC:  reg_rdata_q <= absorb_sec_q;
				CAP_ADDR_EQ_SEC:      reg_rdata_q <= eq_sec_q;
				default:
					if ((reg_addr >= CAP_ADDR_BP_FIRST) && (reg_addr <= CAP_ADDR_BP_LAST))
						reg_rdata_q <= temp_breakpoint_q[3'(reg_addr - CAP_ADDR_BP_FIRST)];
					else
						reg_rdata_q <= 16'h0;
			endcase
		end
	end

	// Fixed strap: a write to the absorb adder leaves it untouched
	property p_fixed_write;
		@(posedge mclk) disable iff (!rst_n)
		(reg_wr && !programmable && ready_q && (reg_addr == CAP_ADDR_ABSORB_ADD))
			|=> $stable(absorb_adder_q);
	endproperty
	a_fixed_write: assert property (p_fixed_write) else $error("fixed write changed bank");

	// Zero threshold never yields taper termination
	property p_taper_off;
		@(posedge mclk) disable iff (!rst_n)
		(taper_current_threshold_q == 16'h0) |-> (state_d != ST_TAPER_TERM || state_q == ST_TAPER_TERM);
	endproperty
	a_taper_off: assert property (p_taper_off) else $error("taper term with zero threshold");

	// Lead-acid never times out in CV
	property p_lead_no_cv_term;
		@(posedge mclk) disable iff (!rst_n)
		(chem == CHEM_LEAD) |-> (state_q != ST_TIMER_TERM && state_q != ST_TIME_FAULT);
	endproperty
	a_lead_no_cv_term: assert property (p_lead_no_cv_term) else $error("lead-acid lithium timer");

	// Iron-phosphate absorb target never passes its ceiling
	property p_lfp_clamp;
		@(posedge mclk) disable iff (!rst_n)
		($past(state_q) == ST_ABSORB && chem == CHEM_LFP && !prof_on)
			|-> (target_q.voltage_code <= CAP_LFP_CODE_MAX);
	endproperty
	a_lfp_clamp: assert property (p_lfp_clamp) else $error("absorb level over ceiling");

	// Li-ion never enters absorb
	property p_li_no_absorb;
		@(posedge mclk) disable iff (!rst_n)
		(chem == CHEM_LI_ION) |-> (state_q != ST_ABSORB);
	endproperty
	a_li_no_absorb: assert property (p_li_no_absorb) else $error("li-ion in absorb");

	// Cold or hot region pauses charging within two cycles
	property p_region_pause;
		@(posedge mclk) disable iff (!rst_n)
		(state_q == ST_CCCV && charge_en && prof_on && region_off && lithium
			&& total_sec_q <= total_charge_time_limit_q) ##1 (charge_en && prof_on && region_off)
			|-> ##1 charge_pause_q;
	endproperty
	a_region_pause: assert property (p_region_pause) else $error("no pause in end region");

	// Absorb counter advances by one on a tick
	property p_absorb_count;
		@(posedge mclk) disable iff (!rst_n)
		(state_q == ST_ABSORB && $past(state_q) == ST_ABSORB && $past(tick_q))
			|-> (absorb_sec_q == $past(absorb_sec_q) + 16'h1);
	endproperty
	a_absorb_count: assert property (p_absorb_count) else $error("absorb seconds stalled");

	// Tick pulse lasts a single cycle
	property p_tick_gap;
		@(posedge mclk) disable iff (!rst_n)
		tick_q |=> !tick_q;
	endproperty
	a_tick_gap: assert property (p_tick_gap) else $error("tick wider than one cycle");

endmodule : cap_bank

// File: hw/cap_pkg.sv
// Constants, types and register map of the charge algorithm parameter bank
package cap_pkg;

	// Register sub-addresses
	localparam logic [7:0] CAP_ADDR_TAPER_THR    = 8'h1C;
	localparam logic [7:0] CAP_ADDR_CV_LIMIT     = 8'h1D;
	localparam logic [7:0] CAP_ADDR_TOTAL_LIMIT  = 8'h1E;
	localparam logic [7:0] CAP_ADDR_BP_FIRST     = 8'h1F;
	localparam logic [7:0] CAP_ADDR_BP_LAST      = 8'h24;
	localparam logic [7:0] CAP_ADDR_VCODE_HI     = 8'h25;
	localparam logic [7:0] CAP_ADDR_VCODE_LO     = 8'h26;
	localparam logic [7:0] CAP_ADDR_ICODE_HI     = 8'h27;
	localparam logic [7:0] CAP_ADDR_ICODE_LO     = 8'h28;
	localparam logic [7:0] CAP_ADDR_CFG          = 8'h29;
	localparam logic [7:0] CAP_ADDR_ABSORB_ADD   = 8'h2A;
	localparam logic [7:0] CAP_ADDR_ABSORB_LIM   = 8'h2B;
	localparam logic [7:0] CAP_ADDR_EQ_ADD       = 8'h2C;
	localparam logic [7:0] CAP_ADDR_EQ_TIME      = 8'h2D;
	localparam logic [7:0] CAP_ADDR_RECHARGE     = 8'h2E;
	localparam logic [7:0] CAP_ADDR_TOTAL_SEC    = 8'h30;
	localparam logic [7:0] CAP_ADDR_CV_SEC       = 8'h31;
	localparam logic [7:0] CAP_ADDR_ABSORB_SEC   = 8'h32;
	localparam logic [7:0] CAP_ADDR_EQ_SEC       = 8'h33;

	// Config field positions
	localparam int CAP_CFG_TAPER_EN = 2;
	localparam int CAP_CFG_TCOMP_EN = 1;
	localparam int CAP_CFG_PROF_EN  = 0;

	// Reset values
	localparam logic [15:0] CAP_RST_TAPER_THR   = 16'h0888;
	localparam logic [15:0] CAP_RST_CV_LI_ION   = 16'h3840;
	localparam logic [15:0] CAP_RST_CV_LFP      = 16'h0E10;
	localparam logic [15:0] CAP_RST_TOTAL_LIMIT = 16'hFFFF;
	localparam logic [15:0] CAP_RST_EQ_TIME     = 16'h0E10;
	localparam logic [15:0] CAP_RST_RECHARGE    = 16'h4410;
	localparam logic [15:0] CAP_RST_ABSORB_LIM  = 16'h0E10;
	localparam logic [15:0] CAP_RST_BP_TOP      = 16'h7000;
	localparam logic [15:0] CAP_RST_BP_STEP     = 16'h1000;
	localparam logic [14:0] CAP_RST_CODE_LO     = 15'h7FFF;
	localparam logic [9:0]  CAP_RST_CODE_HI     = 10'h3FF;
	localparam logic [5:0]  CAP_RST_ADDER       = 6'h00;

	// Highest level codes: 3.8 V/cell iron-phosphate, 2.6 V/cell lead-acid
	localparam logic [6:0] CAP_LFP_CODE_MAX  = 7'h1F;
	localparam logic [6:0] CAP_LEAD_CODE_MAX = 7'h3F;

	// Chemistry strap codes
	localparam logic [2:0] CAP_PIN_LI_PROG   = 3'h0;
	localparam logic [2:0] CAP_PIN_LFP_PROG  = 3'h1;
	localparam logic [2:0] CAP_PIN_LEAD_PROG = 3'h2;
	localparam logic [2:0] CAP_PIN_LI_FIX    = 3'h3;
	localparam logic [2:0] CAP_PIN_LFP_FIX   = 3'h4;

	// One second tick
	localparam longint CAP_SECOND_NS    = 1000000000;
	localparam longint CAP_CLK_PERIOD_NS = 8;
	localparam int     CAP_TICK_CYCLES  = int'(CAP_SECOND_NS / CAP_CLK_PERIOD_NS);
	localparam logic [1:0] CAP_STRAP_SETTLE = 2'h3;

	typedef enum logic [1:0] {CHEM_LI_ION, CHEM_LFP, CHEM_LEAD} cap_chem_t;

	typedef enum {ST_IDLE, ST_CCCV, ST_ABSORB, ST_EQUALIZE, ST_PAUSE,
		ST_TIMER_TERM, ST_TAPER_TERM, ST_TIME_FAULT} cap_state_t;

	// Live measurements and loop flags from the charger
	typedef struct packed {
		logic [15:0] battery_current_reading;
		logic [15:0] ntc_ratio;
		logic        at_target_voltage;
	} cap_meas_t;

	// Targets handed to the regulation loops
	typedef struct packed {
		logic [6:0] voltage_code;
		logic [4:0] current_code;
		logic       temp_comp_en;
	} cap_target_t;

endpackage : cap_pkg

// File: sim/test_cap_bank.sv
// Self-checking bench for the charge algorithm parameter bank
module test_cap_bank
	import cap_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;

	// Bench driven inputs
	logic        mclk;
	logic        rst_n;
	logic [2:0]  chem_pin;
	logic        reg_wr;
	logic        reg_rd;
	logic [7:0]  reg_addr;
	logic [15:0] reg_wdata;
	logic        charge_en;
	logic        equalize_req;
	cap_meas_t   meas;
	// Design outputs
	logic [15:0] reg_rdata_q;
	cap_target_t target_q;
	logic        charge_pause_q;
	logic        terminated_q;
	logic        time_fault_q;
	logic [15:0] recharge_level_q;
	// Bookkeeping
	int          num_errors = 0;
	int          num_checks = 0;
	int          cycles     = 0;

	// Short tick keeps every timer scenario to tens of cycles
	cap_bank #(.TICK_CYCLES(10)) dut (.mclk(mclk), .rst_n(rst_n), .chem_pin(chem_pin),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_rdata_q(reg_rdata_q), .charge_en(charge_en), .equalize_req(equalize_req),
		.charge_voltage_code(6'h10), .charge_current_code(5'h0A), .meas(meas),
		.target_q(target_q), .charge_pause_q(charge_pause_q), .terminated_q(terminated_q),
		.time_fault_q(time_fault_q), .recharge_level_q(recharge_level_q));

	// Free running clock
	initial
	begin
		mclk = 1'b0;
		forever #4 mclk = ~mclk;
	end

	// Verdict, reached from the main flow or the watchdog
	task automatic print_verdict();
		if (num_errors == 0 && num_checks > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask : print_verdict

	// One compare for every 16-bit result
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		num_checks++;
		if (got !== exp)
		begin
			$display("BAD %0t got %h expected %h", $time, got, exp);
			num_errors++;
		end
	endtask : chk

	// Reset for five cycles, then wait past the strap settling
	task automatic do_reset();
		rst_n = 1'b0;
		repeat (5) @(negedge mclk);
		rst_n = 1'b1;
		repeat (10) @(negedge mclk);
	endtask : do_reset

	// Single-cycle write strobe, then one idle cycle before the next request
	task automatic wr(input logic [7:0] a, input logic [15:0] d);
		reg_wr    = 1'b1;
		reg_addr  = a;
		reg_wdata = d;
		@(negedge mclk);
		reg_wr = 1'b0;
		@(negedge mclk);
	endtask : wr

	// Read strobe, data lands one edge later
	task automatic rd(input logic [7:0] a, input logic [15:0] exp);
		reg_rd   = 1'b1;
		reg_addr = a;
		@(negedge mclk);
		reg_rd = 1'b0;
		@(negedge mclk);
		chk(reg_rdata_q, exp);
	endtask : rd

	// Wait a bounded time for termination or fault
	task automatic wait_done(input int n);
		for (int i = 0; i < n && terminated_q !== 1'b1 && time_fault_q !== 1'b1; i++)
			@(negedge mclk);
	endtask : wait_done

	// Watchdog against a hung run
	always @(posedge mclk)
	begin
		cycles <= cycles + 1;
		if (cycles == 5000)
		begin
			num_errors = num_errors + 1;
			print_verdict();
		end
	end

	// Main sequence
	initial
	begin
		rst_n        = 1'b0;
		chem_pin     = CAP_PIN_LI_PROG;
		reg_wr       = 1'b0;
		reg_rd       = 1'b0;
		reg_addr     = 8'h00;
		reg_wdata    = 16'h0000;
		charge_en    = 1'b0;
		equalize_req = 1'b0;
		meas         = '0;
		do_reset();
		chk(recharge_level_q, 16'h4410);
		rd(CAP_ADDR_TAPER_THR, 16'h0888);
		rd(CAP_ADDR_CV_LIMIT, 16'h3840);
		rd(CAP_ADDR_TOTAL_LIMIT, 16'hFFFF);
		rd(CAP_ADDR_EQ_TIME, 16'h0E10);
		rd(CAP_ADDR_CFG, 16'h0001);
		wr(CAP_ADDR_ABSORB_ADD, 16'hFFFF);
		rd(CAP_ADDR_ABSORB_ADD, 16'h003F);
		wr(CAP_ADDR_CV_SEC, 16'h1234);
		rd(CAP_ADDR_CV_SEC, 16'h0000);
		rd(8'h40, 16'h0000);
		// Distinct codes per region, both packing layouts
		wr(CAP_ADDR_VCODE_LO, 16'h1062);
		wr(CAP_ADDR_VCODE_HI, 16'h00C5);
		wr(CAP_ADDR_ICODE_LO, 16'h5272);
		wr(CAP_ADDR_ICODE_HI, 16'h02D5);
		rd(CAP_ADDR_VCODE_LO, 16'h1062);
		charge_en = 1'b1;
		// First ratio lies above all breakpoints, the rest sit exactly on each one, the boundary case
		for (int r = 1; r <= 7; r++)
		begin
			meas.ntc_ratio = 16'h9000 - 16'(r * 16'h1000);
			repeat (4) @(negedge mclk);
			chk({15'h0000, charge_pause_q}, (r == 1 || r == 7) ? 16'h0001 : 16'h0000);
			if (r > 1 && r < 7)
			begin
				chk({9'h000, target_q.voltage_code}, 16'(r));
				chk({11'h000, target_q.current_code}, 16'(r + 16));
			end
		end
		// Constant-voltage timer termination after three seconds
		charge_en = 1'b0;
		wr(CAP_ADDR_CV_LIMIT, 16'h0003);
		meas.ntc_ratio = 16'h6800;
		meas.at_target_voltage = 1'b1;
		charge_en = 1'b1;
		repeat (15) @(negedge mclk);
		chk({15'h0000, terminated_q}, 16'h0000);
		wait_done(40);
		chk({15'h0000, terminated_q}, 16'h0001);
		charge_en = 1'b0;
		repeat (3) @(negedge mclk);
		chk({14'h0000, terminated_q, charge_pause_q}, 16'h0001);
		// Taper termination long before the timer could act
		wr(CAP_ADDR_CFG, 16'h0005);
		meas.battery_current_reading = 16'h0100;
		charge_en = 1'b1;
		wait_done(8);
		chk({15'h0000, terminated_q}, 16'h0001);
		// Zero threshold turns taper detection off
		charge_en = 1'b0;
		wr(CAP_ADDR_TAPER_THR, 16'h0000);
		charge_en = 1'b1;
		repeat (8) @(negedge mclk);
		chk({15'h0000, terminated_q}, 16'h0000);
		// Total time fault needs the count to pass the limit
		charge_en = 1'b0;
		meas.at_target_voltage = 1'b0;
		wr(CAP_ADDR_TOTAL_LIMIT, 16'h0002);
		charge_en = 1'b1;
		repeat (15) @(negedge mclk);
		chk({15'h0000, time_fault_q}, 16'h0000);
		wait_done(40);
		chk({15'h0000, time_fault_q}, 16'h0001);
		charge_en = 1'b0;
		// Lead-acid absorb clamps at its ceiling, then times out to CC-CV
		chem_pin = CAP_PIN_LEAD_PROG;
		do_reset();
		rd(CAP_ADDR_CFG, 16'h0002);
		wr(CAP_ADDR_ABSORB_ADD, 16'h003F);
		wr(CAP_ADDR_ABSORB_LIM, 16'h0002);
		wr(CAP_ADDR_EQ_ADD, 16'h0020);
		wr(CAP_ADDR_EQ_TIME, 16'h0002);
		charge_en = 1'b1;
		repeat (4) @(negedge mclk);
		chk({9'h000, target_q.voltage_code}, 16'h003F);
		chk({15'h0000, target_q.temp_comp_en}, 16'h0001);
		repeat (30) @(negedge mclk);
		chk({9'h000, target_q.voltage_code}, 16'h0010);
		// Sixth adder bit counts in equalize; phase ends after its time
		equalize_req = 1'b1;
		repeat (4) @(negedge mclk);
		chk({9'h000, target_q.voltage_code}, 16'h0030);
		equalize_req = 1'b0;
		repeat (30) @(negedge mclk);
		chk({9'h000, target_q.voltage_code}, 16'h0010);
		// Taper ends lead-acid absorb early, CC-CV then holds
		charge_en = 1'b0;
		wr(CAP_ADDR_ABSORB_LIM, 16'hFFFF);
		charge_en = 1'b1;
		repeat (4) @(negedge mclk);
		chk({9'h000, target_q.voltage_code}, 16'h003F);
		meas.at_target_voltage = 1'b1;
		repeat (4) @(negedge mclk);
		chk({9'h000, target_q.voltage_code}, 16'h0010);
		repeat (30) @(negedge mclk);
		chk({14'h0000, terminated_q, charge_pause_q}, 16'h0000);
		// Iron-phosphate: zero low adder bits skip absorb
		charge_en = 1'b0;
		meas.at_target_voltage = 1'b0;
		chem_pin = CAP_PIN_LFP_PROG;
		do_reset();
		rd(CAP_ADDR_CV_LIMIT, 16'h0E10);
		wr(CAP_ADDR_CFG, 16'h0000);
		wr(CAP_ADDR_ABSORB_ADD, 16'h0020);
		charge_en = 1'b1;
		repeat (15) @(negedge mclk);
		rd(CAP_ADDR_ABSORB_SEC, 16'h0000);
		// Five adder bits clamp at the ceiling; taper moves absorb to CC-CV
		charge_en = 1'b0;
		wr(CAP_ADDR_ABSORB_ADD, 16'h003F);
		charge_en = 1'b1;
		repeat (4) @(negedge mclk);
		chk({9'h000, target_q.voltage_code}, 16'h001F);
		meas.at_target_voltage = 1'b1;
		repeat (4) @(negedge mclk);
		chk({9'h000, target_q.voltage_code}, 16'h0010);
		charge_en = 1'b0;
		// Fixed strap drops writes silently
		chem_pin = CAP_PIN_LI_FIX;
		do_reset();
		wr(CAP_ADDR_TAPER_THR, 16'h1234);
		rd(CAP_ADDR_TAPER_THR, 16'h0888);
		wr(CAP_ADDR_RECHARGE, 16'h0000);
		rd(CAP_ADDR_RECHARGE, 16'h4410);
		wr(CAP_ADDR_ABSORB_ADD, 16'h0015);
		rd(CAP_ADDR_ABSORB_ADD, 16'h0000);
		print_verdict();
	end

endmodule : test_cap_bank
